// File: include/tmc_regs.svh
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// ------------------------------------------------------------------
// clock and time conversion
// ------------------------------------------------------------------
`define TMC_CLK_MHZ          250
// least time in ns to whole cycles, rounded up
`define TMC_NS2CYC_UP(ns)    ((((ns) * `TMC_CLK_MHZ) + 999) / 1000)

// ------------------------------------------------------------------
// timing figures in ns
// ------------------------------------------------------------------
`define TMC_PIN_STABLE_NS    40
`define TMC_UV_DET_NS        1000
`define TMC_UV_REC_NS        1000
`define TMC_GTS_HOLD_NS      20000

// ------------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------------
`define TMC_ADDR_W           4
`define TMC_OFS_STATUS       4'h0
`define TMC_OFS_IRQ_STAT     4'h4
`define TMC_OFS_IRQ_MASK     4'h8

// ------------------------------------------------------------------
// status register fields
// ------------------------------------------------------------------
`define TMC_ST_MODE_LSB      0
`define TMC_ST_LOC_WAKE      3
`define TMC_ST_REM_WAKE      4
`define TMC_ST_WAKE          5
`define TMC_ST_POWER_ON      6
`define TMC_ST_UV_BAT        7
`define TMC_ST_UV_CC         8
`define TMC_ST_UV_IO         9

// ------------------------------------------------------------------
// interrupt status and mask fields, reset values
// ------------------------------------------------------------------
`define TMC_IRQ_W            4
`define TMC_IRQ_LOC          0
`define TMC_IRQ_REM          1
`define TMC_IRQ_UV           2
`define TMC_IRQ_MODE         3
`define TMC_IRQ_MASK_RST     4'h0
`define TMC_IRQ_STAT_RST     4'h0

`endif

// File: include/tmc_pkg.sv
package tmc_pkg;

   // ------------------------------------------------------------------
   // operating modes
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_NORMAL   = 3'b000,
      MODE_RX_ONLY  = 3'b001,
      MODE_STANDBY  = 3'b010,
      MODE_GO_SLEEP = 3'b011,
      MODE_SLEEP    = 3'b100
   } tmc_mode_t;

   // ------------------------------------------------------------------
   // host pin request, coded as {low_power_select_n, mode_en}
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      REQ_STANDBY   = 2'b00,
      REQ_GO_SLEEP  = 2'b01,
      REQ_RX_ONLY   = 2'b10,
      REQ_NORMAL    = 2'b11
   } tmc_req_t;

endpackage : tmc_pkg

// File: logic/tmc_sync.sv
`timescale 1ns/1ns

// two-stage synchroniser; stage one feeds stage two only
module tmc_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   // pins have pull-downs, so reset to all zero
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : tmc_sync

// File: logic/tmc_uv_filter.sv
`timescale 1ns/1ns

// undervoltage flag with separate detect and recovery filter times
module tmc_uv_filter #(
   parameter int DET_CYC = 250,
   parameter int REC_CYC = 250
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic below,
   input  wire logic force_rec,
   output logic      uv_q
);

   localparam int MAXC = (DET_CYC > REC_CYC) ? DET_CYC : REC_CYC;
   localparam int CW   = $clog2(MAXC + 1);

   logic [CW-1:0] cnt_q;
   logic          set_now;
   logic          rec_now;
   logic          uv_d;

   // a detection in the same cycle as a forced recovery still sets
   assign set_now = !uv_q && below && (cnt_q == CW'(DET_CYC - 1));
   assign rec_now = uv_q && !below && (cnt_q == CW'(REC_CYC - 1));
   assign uv_d    = set_now | (uv_q & !rec_now & !force_rec);

   // counter runs only while the comparator disagrees with the flag
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         uv_q  <= 1'b0;
         cnt_q <= '0;
      end else begin
         uv_q  <= uv_d;
         if ((below != uv_q) && (uv_d == uv_q)) begin
            cnt_q <= cnt_q + CW'(1);
         end else begin
            cnt_q <= '0;
         end
      end
   end

   uv_detect_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(uv_q) |-> $past(below) && ($past(cnt_q) == CW'(DET_CYC - 1)))
      else $error("undervoltage flag set without full detect filter");

   uv_recover_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(uv_q) |-> $past(force_rec) || ($past(cnt_q) == CW'(REC_CYC - 1)))
      else $error("undervoltage flag cleared without full recovery filter");

endmodule : tmc_uv_filter

// File: logic/tmc_top.sv
`timescale 1ns/1ns
`include "tmc_regs.svh"

module tmc_top #(
   parameter int DATA_W         = 32,
   parameter int PIN_STABLE_CYC = `TMC_NS2CYC_UP(`TMC_PIN_STABLE_NS),
   parameter int UV_DET_CYC     = `TMC_NS2CYC_UP(`TMC_UV_DET_NS),
   parameter int UV_REC_CYC     = `TMC_NS2CYC_UP(`TMC_UV_REC_NS),
   parameter int GTS_CYC        = `TMC_NS2CYC_UP(`TMC_GTS_HOLD_NS)
) (
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   input  wire logic                   mode_en,
   input  wire logic                   low_power_select_n,
   input  wire logic                   wake_n,
   input  wire logic                   bus_wake,
   input  wire logic                   supply_ok,
   input  wire logic                   uv_bat_below,
   input  wire logic                   uv_cc_below,
   input  wire logic                   uv_io_level_supply_below,
   input  wire logic [`TMC_ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0]      wr_data,
   input  wire logic                   wr_en,
   input  wire logic                   rd_en,
   output logic      [DATA_W-1:0]      rd_data_q,
   output logic                        irq_q,
   output tmc_pkg::tmc_mode_t          mode_q,
   output logic                        bus_connect_q,
   output logic                        tx_path_q,
   output logic                        low_power_q,
   output logic                        reduced_power_q,
   output logic                        host_wake_n_q
);

   localparam int STB_W = $clog2(PIN_STABLE_CYC + 1);
   localparam int GTS_W = $clog2(GTS_CYC + 1);

   // ------------------------------------------------------------------
   // mode group helpers
   // ------------------------------------------------------------------
   function automatic logic is_normal_grp(input tmc_pkg::tmc_mode_t m);
      is_normal_grp = (m == tmc_pkg::MODE_NORMAL) || (m == tmc_pkg::MODE_RX_ONLY);
   endfunction : is_normal_grp

   function automatic logic is_low_grp(input tmc_pkg::tmc_mode_t m);
      is_low_grp = (m == tmc_pkg::MODE_STANDBY) || (m == tmc_pkg::MODE_GO_SLEEP)
                   || (m == tmc_pkg::MODE_SLEEP);
   endfunction : is_low_grp

   // ------------------------------------------------------------------
   // host pin synchronising and stability filter
   // ------------------------------------------------------------------
   logic [1:0]       pins_s;
   logic [1:0]       cand_q;
   logic [1:0]       pins_q;
   logic [STB_W-1:0] stab_cnt_q;

   tmc_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       ({low_power_select_n, mode_en}),
      .q       (pins_s)
   );

   // a combination is only decoded after it held for the full window
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cand_q     <= 2'h0;
         pins_q     <= 2'h0;
         stab_cnt_q <= '0;
      end else if (pins_s != cand_q) begin
         cand_q     <= pins_s;
         stab_cnt_q <= '0;
      end else if (stab_cnt_q != STB_W'(PIN_STABLE_CYC - 1)) begin
         stab_cnt_q <= stab_cnt_q + STB_W'(1);
      end else begin
         pins_q     <= cand_q;
      end
   end

   pin_stable_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(pins_q) |-> ($past(cand_q) == pins_q)
                           && ($past(stab_cnt_q) == STB_W'(PIN_STABLE_CYC - 1)))
      else $error("mode pins decoded before stable window elapsed");

   // ------------------------------------------------------------------
   // supply undervoltage monitoring
   // ------------------------------------------------------------------
   logic [2:0] uv_w;
   logic [2:0] uv_prev_q;
   logic       any_uv;
   logic       uv_rise;
   logic       bat_recovered;
   logic       wake_rise;

   assign any_uv        = |uv_w;
   assign uv_rise       = |(uv_w & ~uv_prev_q);
   assign bat_recovered = uv_prev_q[0] & !uv_w[0];

   // each supply gets its own filter; wake forces recovery of all
   tmc_uv_filter #(.DET_CYC(UV_DET_CYC), .REC_CYC(UV_REC_CYC)) u_uv_bat (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .below     (uv_bat_below),
      .force_rec (wake_rise),
      .uv_q      (uv_w[0])
   );
   tmc_uv_filter #(.DET_CYC(UV_DET_CYC), .REC_CYC(UV_REC_CYC)) u_uv_cc (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .below     (uv_cc_below),
      .force_rec (wake_rise | bat_recovered),
      .uv_q      (uv_w[1])
   );
   tmc_uv_filter #(.DET_CYC(UV_DET_CYC), .REC_CYC(UV_REC_CYC)) u_uv_io (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .below     (uv_io_level_supply_below),
      .force_rec (wake_rise),
      .uv_q      (uv_w[2])
   );

   // previous flags, for edge detection
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         uv_prev_q <= 3'h0;
      end else begin
         uv_prev_q <= uv_w;
      end
   end

   // ------------------------------------------------------------------
   // operating mode state machine
   // ------------------------------------------------------------------
   tmc_pkg::tmc_req_t  req;
   tmc_pkg::tmc_mode_t req_mode;
   tmc_pkg::tmc_mode_t mode_d;
   logic [GTS_W-1:0]   gts_cnt_q;
   logic               wake_q;
   logic               req_normal;

   assign req        = tmc_pkg::tmc_req_t'(pins_q);
   assign req_normal = (req == tmc_pkg::REQ_NORMAL) || (req == tmc_pkg::REQ_RX_ONLY);

   // pin decode; sleep is never requested directly, only go-to-sleep
   always_comb begin
      unique case (req)
         tmc_pkg::REQ_NORMAL:   req_mode = tmc_pkg::MODE_NORMAL;
         tmc_pkg::REQ_RX_ONLY:  req_mode = tmc_pkg::MODE_RX_ONLY;
         tmc_pkg::REQ_GO_SLEEP: req_mode = tmc_pkg::MODE_GO_SLEEP;
         tmc_pkg::REQ_STANDBY:  req_mode = tmc_pkg::MODE_STANDBY;
      endcase
   end

   // next mode from pins, undervoltage and pending wakeup
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         tmc_pkg::MODE_NORMAL, tmc_pkg::MODE_RX_ONLY: begin
            if (any_uv) begin
               mode_d = tmc_pkg::MODE_STANDBY;
            end else begin
               mode_d = req_mode;
            end
         end
         tmc_pkg::MODE_STANDBY: begin
            if (!any_uv && req_normal) begin
               mode_d = req_mode;
            end else if ((req == tmc_pkg::REQ_GO_SLEEP) && !wake_q) begin
               mode_d = tmc_pkg::MODE_GO_SLEEP;
            end
         end
         tmc_pkg::MODE_GO_SLEEP: begin
            if (wake_q) begin
               mode_d = tmc_pkg::MODE_STANDBY;
            end else if (!any_uv && req_normal) begin
               mode_d = req_mode;
            end else if (req == tmc_pkg::REQ_STANDBY) begin
               mode_d = tmc_pkg::MODE_STANDBY;
            end else if (gts_cnt_q == GTS_W'(GTS_CYC - 1)) begin
               mode_d = tmc_pkg::MODE_SLEEP;
            end
         end
         tmc_pkg::MODE_SLEEP: begin
            if (wake_q) begin
               mode_d = tmc_pkg::MODE_STANDBY;
            end else if (!any_uv && req_normal) begin
               mode_d = req_mode;
            end
         end
         default: mode_d = tmc_pkg::MODE_STANDBY;
      endcase
   end

   // mode register and go-to-sleep dwell counter
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mode_q    <= tmc_pkg::MODE_STANDBY;
         gts_cnt_q <= '0;
      end else begin
         mode_q    <= mode_d;
         if ((mode_q == tmc_pkg::MODE_GO_SLEEP) && (mode_d == tmc_pkg::MODE_GO_SLEEP)) begin
            gts_cnt_q <= gts_cnt_q + GTS_W'(1);
         end else begin
            gts_cnt_q <= '0;
         end
      end
   end

   sleep_via_gts_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
      (mode_q == tmc_pkg::MODE_SLEEP) && ($past(mode_q) != tmc_pkg::MODE_SLEEP)
      |-> ($past(mode_q) == tmc_pkg::MODE_GO_SLEEP)
          && ($past(gts_cnt_q) == GTS_W'(GTS_CYC - 1)))
      else $error("sleep entered without full go-to-sleep dwell");

   pins_followed_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
      is_normal_grp(mode_q) && !any_uv && (req == tmc_pkg::REQ_RX_ONLY)
      |=> (mode_q == tmc_pkg::MODE_RX_ONLY))
      else $error("receive-only request not followed with good supplies");

   uv_leaves_normal_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
      is_normal_grp(mode_q) && any_uv |=> (mode_q == tmc_pkg::MODE_STANDBY))
      else $error("undervoltage did not force standby");

   // ------------------------------------------------------------------
   // wakeup and power-on flags
   // ------------------------------------------------------------------
   logic lp_now;
   logic lp_entry;
   logic normal_entry;
   logic loc_set;
   logic rem_set;
   logic loc_q;
   logic rem_q;
   logic loc_rise;
   logic rem_rise;
   logic wake_d;
   logic por_q;
   logic sup_prev_q;

   assign lp_now       = is_low_grp(mode_q);
   assign lp_entry     = is_low_grp(mode_d) && !lp_now;
   assign normal_entry = (mode_d == tmc_pkg::MODE_NORMAL) && (mode_q != tmc_pkg::MODE_NORMAL);
   assign loc_set      = lp_now && !wake_n;
   assign rem_set      = lp_now && bus_wake;
   assign loc_rise     = loc_set && !loc_q;
   assign rem_rise     = rem_set && !rem_q;
   // set beats every clear arriving in the same cycle
   assign wake_d       = loc_rise | rem_rise
                         | (wake_q & !(normal_entry | lp_entry | uv_rise));
   assign wake_rise    = wake_d && !wake_q;

   // sticky flags, set wins over clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         loc_q      <= 1'b0;
         rem_q      <= 1'b0;
         wake_q     <= 1'b0;
         por_q      <= 1'b0;
         sup_prev_q <= 1'b0;
      end else begin
         loc_q      <= loc_set | (loc_q & !lp_entry);
         rem_q      <= rem_set | (rem_q & !lp_entry);
         wake_q     <= wake_d;
         sup_prev_q <= supply_ok;
         por_q      <= (supply_ok & !sup_prev_q) | (por_q & !normal_entry);
      end
   end

   loc_wake_set_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
      lp_now && !wake_n |=> loc_q)
      else $error("local wake flag missed a low wake input");

   rem_wake_clr_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
      lp_entry && !rem_set |=> !rem_q)
      else $error("remote wake flag not cleared on low-power entry");

   wake_comb_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(loc_q) || $rose(rem_q) |-> wake_q)
      else $error("combined wake flag not set by a wake source");

   power_on_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
      supply_ok && !sup_prev_q |=> por_q ##0 (!normal_entry [*1]))
      else $error("power-on flag not set on supply good");

   // ------------------------------------------------------------------
   // mode-dependent outputs, registered from the next mode
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bus_connect_q   <= 1'b0;
         tx_path_q       <= 1'b0;
         low_power_q     <= 1'b1;
         reduced_power_q <= 1'b1;
         host_wake_n_q   <= 1'b1;
      end else begin
         bus_connect_q   <= is_normal_grp(mode_d);
         tx_path_q       <= (mode_d == tmc_pkg::MODE_NORMAL);
         low_power_q     <= is_low_grp(mode_d);
         reduced_power_q <= (mode_d == tmc_pkg::MODE_STANDBY)
                            || (mode_d == tmc_pkg::MODE_SLEEP);
         host_wake_n_q   <= !(wake_d && is_low_grp(mode_d));
      end
   end

   bus_connect_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
      bus_connect_q == is_normal_grp(mode_q))
      else $error("bus connection does not match mode");

   reduced_pwr_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
      reduced_power_q |-> !bus_connect_q && low_power_q)
      else $error("reduced power while bus connected");

   host_wake_a : assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(loc_q) && is_low_grp(mode_q) |-> !host_wake_n_q)
      else $error("host not told of local wakeup");

   sleep_seen_c    : cover property (@(posedge clk_sys) disable iff (!rst_n)
      (mode_q == tmc_pkg::MODE_GO_SLEEP) ##1 (mode_q == tmc_pkg::MODE_SLEEP));
   wake_standby_c  : cover property (@(posedge clk_sys) disable iff (!rst_n)
      (mode_q == tmc_pkg::MODE_SLEEP) ##1 (mode_q == tmc_pkg::MODE_STANDBY) && wake_q);
   normal_seen_c   : cover property (@(posedge clk_sys) disable iff (!rst_n)
      (mode_q == tmc_pkg::MODE_STANDBY) ##1 (mode_q == tmc_pkg::MODE_NORMAL));

   // ------------------------------------------------------------------
   // register slave and interrupt
   // ------------------------------------------------------------------
   logic [`TMC_IRQ_W-1:0] irq_stat_q;
   logic [`TMC_IRQ_W-1:0] irq_stat_d;
   logic [`TMC_IRQ_W-1:0] irq_mask_q;
   logic [`TMC_IRQ_W-1:0] irq_ev;
   logic [DATA_W-1:0]     status_w;
   logic [DATA_W-1:0]     rd_mux;
   logic                  stat_rd;

   assign stat_rd = rd_en && (addr == `TMC_OFS_IRQ_STAT);

   // events; a read clear never swallows an event of the same cycle
   always_comb begin
      irq_ev                = '0;
      irq_ev[`TMC_IRQ_LOC]  = loc_rise;
      irq_ev[`TMC_IRQ_REM]  = rem_rise;
      irq_ev[`TMC_IRQ_UV]   = uv_rise;
      irq_ev[`TMC_IRQ_MODE] = (mode_d != mode_q);
      irq_stat_d            = (stat_rd ? `TMC_IRQ_STAT_RST : irq_stat_q) | irq_ev;
   end

   // status word and read mux; unmapped reads return zero
   always_comb begin
      status_w                             = '0;
      status_w[`TMC_ST_MODE_LSB +: 3]      = mode_q;
      status_w[`TMC_ST_LOC_WAKE]           = loc_q;
      status_w[`TMC_ST_REM_WAKE]           = rem_q;
      status_w[`TMC_ST_WAKE]               = wake_q;
      status_w[`TMC_ST_POWER_ON]           = por_q;
      status_w[`TMC_ST_UV_BAT]             = uv_w[0];
      status_w[`TMC_ST_UV_CC]              = uv_w[1];
      status_w[`TMC_ST_UV_IO]              = uv_w[2];
      rd_mux                               = '0;
      unique case (addr)
         `TMC_OFS_STATUS:   rd_mux = status_w;
         `TMC_OFS_IRQ_STAT: rd_mux[`TMC_IRQ_W-1:0] = irq_stat_q;
         `TMC_OFS_IRQ_MASK: rd_mux[`TMC_IRQ_W-1:0] = irq_mask_q;
         default:           rd_mux = '0;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_data_q  <= '0;
         irq_stat_q <= `TMC_IRQ_STAT_RST;
         irq_mask_q <= `TMC_IRQ_MASK_RST;
         irq_q      <= 1'b0;
      end else begin
         rd_data_q  <= rd_en ? rd_mux : '0;
         irq_stat_q <= irq_stat_d;
         if (wr_en && (addr == `TMC_OFS_IRQ_MASK)) begin
            irq_mask_q <= wr_data[`TMC_IRQ_W-1:0];
            irq_q      <= |(irq_stat_d & wr_data[`TMC_IRQ_W-1:0]);
         end else begin
            irq_q      <= |(irq_stat_d & irq_mask_q);
         end
      end
   end

endmodule : tmc_top

// File: dv/tmc_host_model.sv
`timescale 1ns/1ns

// host side of the mode pins, coded {low_power_select_n, mode_en}
module tmc_host_model (
   input  wire logic       clk_sys,
   input  wire logic [1:0] req,
   output logic            mode_en = 1'b0,
   output logic            low_power_select_n = 1'b0
);
   // pins move just after an edge, like an unclocked host seen late
   always @(posedge clk_sys) begin
      {low_power_select_n, mode_en} <= req;
   end
endmodule : tmc_host_model

// File: dv/transceiver_mode_control_tb.sv
`timescale 1ns/1ns

// mode controller bench with small filter counts to keep runs short
module transceiver_mode_control_tb;
   logic               clk_sys = 1'b0;
   logic               rst_n = 1'b0;
   logic               wake_n = 1'b1;
   logic               bus_wake = 1'b0;
   logic               uv_bat = 1'b0;
   logic               supply_ok = 1'b1;
   logic               uv_cc = 1'b0;
   logic               uv_io = 1'b0;
   logic               wr_en = 1'b0;
   logic               rd_en = 1'b0;
   logic [3:0]         addr = 4'h0;
   logic [31:0]        wr_data = 32'h0;
   logic [1:0]         req = 2'h0;
   logic [31:0]        rd_data_q;
   logic               mode_en, low_power_select_n, irq_q, bus_connect_q, tx_path_q;
   logic               low_power_q, reduced_power_q, host_wake_n_q;
   tmc_pkg::tmc_mode_t mode_q;
   int                 error_cnt = 0;
   int                 n_checks = 0;

   initial forever #2 clk_sys = ~clk_sys;

   tmc_host_model host (.clk_sys(clk_sys), .req(req), .mode_en(mode_en),
      .low_power_select_n(low_power_select_n));
   tmc_top #(.PIN_STABLE_CYC(2), .UV_DET_CYC(4), .UV_REC_CYC(4), .GTS_CYC(8)) uut (
      .clk_sys(clk_sys), .rst_n(rst_n), .mode_en(mode_en),
      .low_power_select_n(low_power_select_n), .wake_n(wake_n), .bus_wake(bus_wake),
      .supply_ok(supply_ok), .uv_bat_below(uv_bat), .uv_cc_below(uv_cc),
      .uv_io_level_supply_below(uv_io), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data_q(rd_data_q), .irq_q(irq_q), .mode_q(mode_q),
      .bus_connect_q(bus_connect_q), .tx_path_q(tx_path_q), .low_power_q(low_power_q),
      .reduced_power_q(reduced_power_q), .host_wake_n_q(host_wake_n_q));

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : chk

   // read data stands only in the cycle after the strobe
   task automatic rdc(input string n, input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      chk(n, e, rd_data_q);
   endtask : rdc

   // bounded wait; a hang ends the run rather than stalling it
   task automatic go(input logic [1:0] r, input tmc_pkg::tmc_mode_t m);
      int i;
      @(posedge clk_sys);
      req <= r;
      #1;
      for (i = 0; i < 100 && mode_q !== m; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk("mode", m, mode_q);
      if (mode_q !== m)
         end_sim;
   endtask : go

   task automatic t_normal;
      @(posedge clk_sys);
      addr <= 4'h8;
      wr_data <= 32'h8;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      go(2'b11, tmc_pkg::MODE_NORMAL);
      chk("paths", 32'h6, {bus_connect_q, tx_path_q, low_power_q});
      chk("irq", 32'h1, irq_q);
      rdc("irq_stat", 4'h4, 32'h8);
      chk("irq", 32'h0, irq_q);
      rdc("status", 4'h0, 32'h0);
      rdc("unmapped", 4'hc, 32'h0);
      rdc("irq_mask", 4'h8, 32'h8);
      go(2'b10, tmc_pkg::MODE_RX_ONLY);
      chk("paths", 32'h4, {bus_connect_q, tx_path_q, low_power_q});
      $display("normal test done");
   endtask : t_normal

   // sleep only via go-to-sleep, then wake by both sources
   task automatic t_sleep_wake;
      go(2'b01, tmc_pkg::MODE_GO_SLEEP);
      go(2'b01, tmc_pkg::MODE_SLEEP);
      chk("power", 32'h3, {reduced_power_q, low_power_q});
      @(posedge clk_sys);
      wake_n <= 1'b0;
      go(2'b01, tmc_pkg::MODE_STANDBY);
      chk("host_wake", 32'h0, host_wake_n_q);
      @(posedge clk_sys);
      bus_wake <= 1'b1;
      wake_n <= 1'b1;
      @(posedge clk_sys);
      bus_wake <= 1'b0;
      rdc("status", 4'h0, 32'h3a);
      go(2'b11, tmc_pkg::MODE_NORMAL);
      rdc("status", 4'h0, 32'h18);
      @(posedge clk_sys);
      uv_bat <= 1'b1;
      go(2'b11, tmc_pkg::MODE_STANDBY);
      rdc("status", 4'h0, 32'h82);
      @(posedge clk_sys);
      uv_bat <= 1'b0;
      $display("sleep and wake test done");
   endtask : t_sleep_wake

   // core and io supply dips, a fresh power-on edge, then a standby request
   task automatic t_supply;
      go(2'b11, tmc_pkg::MODE_NORMAL);
      @(posedge clk_sys);
      uv_cc <= 1'b1;
      go(2'b11, tmc_pkg::MODE_STANDBY);
      rdc("status", 4'h0, 32'h102);
      @(posedge clk_sys);
      uv_cc <= 1'b0;
      go(2'b11, tmc_pkg::MODE_NORMAL);
      @(posedge clk_sys);
      uv_io <= 1'b1;
      go(2'b11, tmc_pkg::MODE_STANDBY);
      rdc("status", 4'h0, 32'h202);
      @(posedge clk_sys);
      uv_io <= 1'b0;
      go(2'b11, tmc_pkg::MODE_NORMAL);
      @(posedge clk_sys);
      supply_ok <= 1'b0;
      @(posedge clk_sys);
      supply_ok <= 1'b1;
      rdc("status", 4'h0, 32'h40);
      go(2'b00, tmc_pkg::MODE_STANDBY);
      chk("host_wake", 32'h1, host_wake_n_q);
      $display("supply test done");
   endtask : t_supply

   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      chk("reset", 32'h3, {bus_connect_q, reduced_power_q, low_power_q});
      rdc("status", 4'h0, 32'h42);
      $display("reset test done");
      t_normal;
      t_sleep_wake;
      t_supply;
      end_sim;
   end
endmodule : transceiver_mode_control_tb
